// ### csr_pkg.sv
// Constants for the core special-function register block
package csr_pkg;
   localparam logic [6:0] ADDR_INDIRECT_WINDOW = 7'h00;
   localparam logic [6:0] ADDR_TIMER_COUNT = 7'h01;
   localparam logic [6:0] ADDR_PC_LOW_BYTE = 7'h02;
   localparam logic [6:0] ADDR_FLAGS = 7'h03;
   localparam logic [6:0] ADDR_FILE_SELECT = 7'h04;
   localparam logic [6:0] ADDR_PC_HIGH_BUFFER = 7'h0A;
   localparam logic [6:0] SFR_TOP = 7'h1F;
   localparam int PC_WIDTH = 10;
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_NIBBLE = 1;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_POWER_DOWN = 3;
   localparam int FLAG_EXPIRY = 4;
   localparam int FLAG_SPARE = 5;
   localparam int FLAG_BANK_LO = 6;
   localparam int FLAG_BANK_HI = 7;
   localparam logic [7:0] FLAGS_RESET = 8'h18;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [9:0] PC_RESET = 10'h000;
   localparam logic [1:0] PCHB_RESET = 2'h0;
   localparam logic [7:0] TIMER_RESET = 8'h00;
   // Timer source selections
   typedef enum logic [1:0] {CSR_SRC_INSTR, CSR_SRC_EXT, CSR_SRC_LOWOSC} csr_src_type;
endpackage : csr_pkg

// ### csr_timer_count.sv
// Timer counter with selectable count source and direct load
`timescale 1ns/10ps
`default_nettype none
module csr_timer_count
   import csr_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic instrTick,
   input wire logic extCountSync,
   input wire logic lowOscSync,
   input wire logic timerSourceMode,
   input wire logic cfgLowOsc,
   input wire logic loadEn,
   input wire logic [7:0] loadData,
   output logic [7:0] count
);
   logic [7:0] count_reg, count_next;
   logic extPrev_reg, lowPrev_reg;
   logic tick;
   csr_src_type src;

   always_comb begin
      if (!timerSourceMode) src = CSR_SRC_INSTR;
      else if (cfgLowOsc) src = CSR_SRC_LOWOSC;
      else src = CSR_SRC_EXT;
      case (src)
         CSR_SRC_INSTR: tick = instrTick;
         CSR_SRC_EXT: tick = extCountSync & ~extPrev_reg;
         CSR_SRC_LOWOSC: tick = lowOscSync & ~lowPrev_reg;
         default: tick = 1'b0;
      endcase
      count_next = count_reg;
      if (loadEn) count_next = loadData;
      else if (tick) count_next = count_reg + 8'h01;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= TIMER_RESET;
         extPrev_reg <= 1'b0;
         lowPrev_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         extPrev_reg <= extCountSync;
         lowPrev_reg <= lowOscSync;
      end
   end
   assign count = count_reg;
endmodule : csr_timer_count
`default_nettype wire

// ### csr_core_regs.sv
// Core special-function registers: indirect window, timer, PC, flags, pointer
// Operation
// - Window at 0x0 has no storage; accesses go to pointer-selected register.
// - Timer register reads live count; writes replace the count immediately.
// - Timer counts instruction clock, external pin or low oscillator.
// - PC is 10 bits, low byte read/write, increments after each instruction.
// - Register writes reach PC upper bits only through the high-byte buffer.
// - Long jump loads all ten PC bits from instruction word.
// - Long call loads PC and pushes PC+1 onto return stack.
// - Carry set on add carry or subtract without borrow.
// - Nibble flag set on low nibble carry or no nibble borrow.
// - Zero flag set when operation result is zero.
// - Power-down flag set at power-up and watchdog clear, cleared by sleep.
// - Expiry flag set at power-up, watchdog clear, sleep; cleared on timeout.
// - Flag bits 7:6 select data bank, reset zero.
// - Pointer bits 6:0 select one of 128 locations for indirect access.
// - Flag bit 5 and pointer bit 7 are plain storage, reset zero.
// - Indirect access uses bank bits and seven pointer bits.
// - Addresses 0x0-0x1F in every bank map to bank 0 registers.
`timescale 1ns/10ps
`default_nettype none
module csr_core_regs
   import csr_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic instrDone,
   input wire logic [1:0] accBank,
   input wire logic [6:0] accAddr,
   input wire logic accIndirect,
   input wire logic accRead,
   input wire logic accWrite,
   input wire logic [7:0] accWdata,
   output logic [7:0] accRdata,
   output logic [8:0] memAddr,
   output logic memRead,
   output logic memWrite,
   output logic [7:0] memWdata,
   input wire logic [7:0] memRdata,
   input wire logic longJump,
   input wire logic longSubroutineJump,
   input wire logic [9:0] jumpTarget,
   output logic stackPush,
   output logic [9:0] stackData,
   output logic [9:0] pcOut,
   input wire logic flagUpdate,
   input wire logic [2:0] flagMask,
   input wire logic carryIn,
   input wire logic nibbleIn,
   input wire logic [7:0] resultIn,
   input wire logic watchdogClearInstr,
   input wire logic sleepInstr,
   input wire logic watchdogTimeout,
   input wire logic timerSourceMode,
   input wire logic cfgLowOsc,
   input wire logic externalCountInput,
   input wire logic lowOscClock,
   output logic [1:0] bankSelect,
   output logic [6:0] pointerLoc
);
   logic [9:0] pc_reg, pc_next;
   logic [1:0] pcHigh_reg, pcHigh_next;
   logic [7:0] flags_reg, flags_next;
   logic [7:0] ptr_reg, ptr_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [8:0] mAddr_reg, mAddr_next;
   logic mRd_reg, mRd_next, mWr_reg, mWr_next;
   logic [7:0] mWd_reg, mWd_next;
   logic push_reg, push_next;
   logic [9:0] stk_reg, stk_next;
   logic [1:0] extSync_reg, lowSync_reg;
   logic [1:0] effBank;
   logic [6:0] effAddr;
   logic isSfr, tmrWrite;
   logic [7:0] timerCount;

   // Two flops before the counter reads the pins
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         extSync_reg <= 2'h0;
         lowSync_reg <= 2'h0;
      end else begin
         extSync_reg <= {extSync_reg[0], externalCountInput};
         lowSync_reg <= {lowSync_reg[0], lowOscClock};
      end
   end

   always_comb begin
      // Indirect path replaces the operand address entirely
      if (accIndirect || accAddr == ADDR_INDIRECT_WINDOW) begin
         effBank = flags_reg[FLAG_BANK_HI:FLAG_BANK_LO];
         effAddr = ptr_reg[6:0];
      end else begin
         effBank = accBank;
         effAddr = accAddr;
      end
      isSfr = effAddr <= SFR_TOP;
      tmrWrite = accWrite && isSfr && effAddr == ADDR_TIMER_COUNT;
   end

   csr_timer_count u_timer (
      .core_clk(core_clk),
      .resetn(resetn),
      .instrTick(instrDone),
      .extCountSync(extSync_reg[1]),
      .lowOscSync(lowSync_reg[1]),
      .timerSourceMode(timerSourceMode),
      .cfgLowOsc(cfgLowOsc),
      .loadEn(tmrWrite),
      .loadData(accWdata),
      .count(timerCount)
   );

   always_comb begin
      pc_next = pc_reg;
      pcHigh_next = pcHigh_reg;
      flags_next = flags_reg;
      ptr_next = ptr_reg;
      rdata_next = rdata_reg;
      mAddr_next = {effBank, effAddr};
      mRd_next = 1'b0;
      mWr_next = 1'b0;
      mWd_next = accWdata;
      push_next = 1'b0;
      stk_next = stk_reg;
      if (instrDone) pc_next = pc_reg + 10'h001;
      if (flagUpdate) begin
         if (flagMask[0]) flags_next[FLAG_CARRY] = carryIn;
         if (flagMask[1]) flags_next[FLAG_NIBBLE] = nibbleIn;
         if (flagMask[2]) flags_next[FLAG_ZERO] = (resultIn == 8'h00);
      end
      // Memory answers on the registered address, so its byte is taken a cycle later
      if (mRd_reg) rdata_next = memRdata;
      if (accRead) begin
         if (isSfr) begin
            case (effAddr)
               ADDR_TIMER_COUNT: rdata_next = timerCount;
               ADDR_PC_LOW_BYTE: rdata_next = pc_reg[7:0];
               ADDR_FLAGS: rdata_next = flags_reg;
               ADDR_FILE_SELECT: rdata_next = ptr_reg;
               ADDR_PC_HIGH_BUFFER: rdata_next = {6'h00, pcHigh_reg};
               default: rdata_next = 8'h00;
            endcase
         end else begin
            mRd_next = 1'b1;
         end
      end
      if (accWrite) begin
         if (isSfr) begin
            case (effAddr)
               ADDR_PC_LOW_BYTE: pc_next = {pcHigh_reg, accWdata};
               ADDR_FLAGS: flags_next = accWdata;
               ADDR_FILE_SELECT: ptr_next = accWdata;
               ADDR_PC_HIGH_BUFFER: pcHigh_next = accWdata[1:0];
               default: ;
            endcase
         end else begin
            mWr_next = 1'b1;
         end
      end
      if (longJump) pc_next = jumpTarget;
      if (longSubroutineJump) begin
         pc_next = jumpTarget;
         push_next = 1'b1;
         stk_next = pc_reg + 10'h001;
      end
      // Hardware events override a same-cycle software write of the flag
      if (watchdogClearInstr) begin
         flags_next[FLAG_POWER_DOWN] = 1'b1;
         flags_next[FLAG_EXPIRY] = 1'b1;
      end
      if (sleepInstr) begin
         flags_next[FLAG_POWER_DOWN] = 1'b0;
         flags_next[FLAG_EXPIRY] = 1'b1;
      end
      if (watchdogTimeout) flags_next[FLAG_EXPIRY] = 1'b0;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pc_reg <= PC_RESET;
         pcHigh_reg <= PCHB_RESET;
         flags_reg <= FLAGS_RESET;
         ptr_reg <= POINTER_RESET;
         rdata_reg <= 8'h00;
         mAddr_reg <= 9'h000;
         mRd_reg <= 1'b0;
         mWr_reg <= 1'b0;
         mWd_reg <= 8'h00;
         push_reg <= 1'b0;
         stk_reg <= 10'h000;
      end else begin
         pc_reg <= pc_next;
         pcHigh_reg <= pcHigh_next;
         flags_reg <= flags_next;
         ptr_reg <= ptr_next;
         rdata_reg <= rdata_next;
         mAddr_reg <= mAddr_next;
         mRd_reg <= mRd_next;
         mWr_reg <= mWr_next;
         mWd_reg <= mWd_next;
         push_reg <= push_next;
         stk_reg <= stk_next;
      end
   end

   assign accRdata = rdata_reg;
   assign memAddr = mAddr_reg;
   assign memRead = mRd_reg;
   assign memWrite = mWr_reg;
   assign memWdata = mWd_reg;
   assign stackPush = push_reg;
   assign stackData = stk_reg;
   assign pcOut = pc_reg;
   assign bankSelect = flags_reg[FLAG_BANK_HI:FLAG_BANK_LO];
   assign pointerLoc = ptr_reg[6:0];

   a_jump_load: assert property (@(posedge core_clk) disable iff (!resetn)
      longJump && !longSubroutineJump |=> pcOut == $past(jumpTarget))
      else $error("long jump did not load PC");
   a_call_push: assert property (@(posedge core_clk) disable iff (!resetn)
      longSubroutineJump |=> stackPush && stackData == $past(pcOut) + 10'h001 && pcOut == $past(jumpTarget))
      else $error("long call push wrong");
   a_pc_step: assert property (@(posedge core_clk) disable iff (!resetn)
      instrDone && !accWrite && !longJump && !longSubroutineJump |=> pcOut == $past(pcOut) + 10'h001)
      else $error("PC did not advance");
   a_pcl_atomic: assert property (@(posedge core_clk) disable iff (!resetn)
      accWrite && !accIndirect && accAddr == ADDR_PC_LOW_BYTE && !longJump && !longSubroutineJump
      |=> pcOut == {$past(pcHigh_reg), $past(accWdata)})
      else $error("PC low write not atomic");
   a_zero_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      flagUpdate && flagMask[2] && !accWrite |=> flags_reg[FLAG_ZERO] == ($past(resultIn) == 8'h00))
      else $error("zero flag wrong");
   a_carry_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      flagUpdate && flagMask[0] && !accWrite |=> flags_reg[FLAG_CARRY] == $past(carryIn))
      else $error("carry flag wrong");
   a_sleep_flags: assert property (@(posedge core_clk) disable iff (!resetn)
      sleepInstr && !watchdogTimeout |=> !flags_reg[FLAG_POWER_DOWN] && flags_reg[FLAG_EXPIRY])
      else $error("sleep flags wrong");
   a_timeout_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      watchdogTimeout |=> !flags_reg[FLAG_EXPIRY])
      else $error("timeout flag not cleared");
   a_indirect_addr: assert property (@(posedge core_clk) disable iff (!resetn)
      (accIndirect || accAddr == ADDR_INDIRECT_WINDOW) && accRead && !isSfr
      |=> memRead && memAddr == {$past(bankSelect), $past(pointerLoc)})
      else $error("indirect address wrong");
endmodule : csr_core_regs
`default_nettype wire

// ### csr_gpr_model.sv
// Data memory model behind the special-register block
`timescale 1ns/10ps
`default_nettype none
module csr_gpr_model (
   input wire logic core_clk,
   input wire logic [8:0] memAddr,
   input wire logic memRead,
   input wire logic memWrite,
   input wire logic [7:0] memWdata,
   output logic [7:0] memRdata,
   output logic [8:0] lastAddr,
   output logic [7:0] lastData
);
   logic [7:0] mem [0:511];
   // Never-written cells read unknown, so no stale match can pass
   assign memRdata = mem[memAddr];
   always @(posedge core_clk) begin
      if (memWrite) begin
         mem[memAddr] <= memWdata;
         lastAddr <= memAddr;
         lastData <= memWdata;
      end
   end
endmodule : csr_gpr_model
`default_nettype wire

// ### test_core_special_registers.sv
// Self-checking bench for the core special-function registers
`timescale 1ns/10ps
`default_nettype none
module test_core_special_registers;
   import csr_pkg::*;
   logic core_clk, resetn, instrDone, accIndirect, accRead, accWrite, longJump, longSubroutineJump;
   logic flagUpdate, carryIn, nibbleIn, watchdogClearInstr, sleepInstr, watchdogTimeout;
   logic timerSourceMode, cfgLowOsc, externalCountInput, lowOscClock, memRead, memWrite, stackPush;
   logic [1:0] accBank, bankSelect;
   logic [6:0] accAddr, pointerLoc;
   logic [7:0] accWdata, accRdata, memWdata, memRdata, resultIn, lastData, q;
   logic [8:0] memAddr, lastAddr;
   logic [9:0] jumpTarget, stackData, pcOut;
   logic [2:0] flagMask;
   int error_cnt = 0;
   int n_checks = 0;

   csr_core_regs u_csr_core_regs (.core_clk(core_clk), .resetn(resetn), .instrDone(instrDone),
      .accBank(accBank), .accAddr(accAddr), .accIndirect(accIndirect), .accRead(accRead),
      .accWrite(accWrite), .accWdata(accWdata), .accRdata(accRdata), .memAddr(memAddr),
      .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata),
      .longJump(longJump), .longSubroutineJump(longSubroutineJump), .jumpTarget(jumpTarget),
      .stackPush(stackPush), .stackData(stackData), .pcOut(pcOut), .flagUpdate(flagUpdate),
      .flagMask(flagMask), .carryIn(carryIn), .nibbleIn(nibbleIn), .resultIn(resultIn),
      .watchdogClearInstr(watchdogClearInstr), .sleepInstr(sleepInstr),
      .watchdogTimeout(watchdogTimeout), .timerSourceMode(timerSourceMode), .cfgLowOsc(cfgLowOsc),
      .externalCountInput(externalCountInput), .lowOscClock(lowOscClock),
      .bankSelect(bankSelect), .pointerLoc(pointerLoc));
   csr_gpr_model u_csr_gpr_model (.core_clk(core_clk), .memAddr(memAddr), .memRead(memRead),
      .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata), .lastAddr(lastAddr),
      .lastData(lastData));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out

   // One register access; SFR read data lands on the edge that takes the strobe, memory read data a cycle later
   task automatic acc(input logic [6:0] a, input logic wr, input logic [7:0] d);
      @(posedge core_clk);
      accAddr <= a;
      accWdata <= d;
      accWrite <= wr;
      accRead <= ~wr;
      @(posedge core_clk);
      accWrite <= 1'b0;
      accRead <= 1'b0;
      @(posedge core_clk);
      #1 q = accRdata;
   endtask : acc

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge core_clk);
         instrDone <= 1'b1;
         @(posedge core_clk);
         instrDone <= 1'b0;
      end
      #1;
   endtask : tick

   task automatic t_reset();
      acc(ADDR_FLAGS, 0, 8'h00); chk("flags", q, 10'h018);
      acc(ADDR_FILE_SELECT, 0, 8'h00); chk("pointer", q, 10'h000);
      acc(ADDR_PC_LOW_BYTE, 0, 8'h00); chk("pc low", q, 10'h000);
      $display("reset test done");
   endtask : t_reset

   task automatic t_pc();
      acc(ADDR_PC_HIGH_BUFFER, 1, 8'h01);
      chk("pc untouched", pcOut, 10'h000);
      acc(ADDR_PC_LOW_BYTE, 1, 8'h34); chk("pc load", pcOut, 10'h134);
      tick(1); chk("pc step", pcOut, 10'h135);
      @(posedge core_clk);
      longSubroutineJump <= 1'b1;
      jumpTarget <= 10'h200;
      @(posedge core_clk);
      longSubroutineJump <= 1'b0;
      #1 chk("call pc", pcOut, 10'h200);
      chk("push", {9'h000, stackPush}, 10'h001);
      chk("push data", stackData, 10'h136);
      @(posedge core_clk);
      longJump <= 1'b1;
      jumpTarget <= 10'h3FF;
      @(posedge core_clk);
      longJump <= 1'b0;
      #1 chk("jump pc", pcOut, 10'h3FF);
      tick(1); chk("pc wrap", pcOut, 10'h000);
      $display("pc test done");
   endtask : t_pc

   task automatic t_flags();
      acc(ADDR_FLAGS, 1, 8'hF8); chk("bank", bankSelect, 10'h003);
      @(posedge core_clk);
      flagUpdate <= 1'b1;
      flagMask <= 3'h7;
      carryIn <= 1'b1;
      nibbleIn <= 1'b1;
      resultIn <= 8'h00;
      @(posedge core_clk);
      flagMask <= 3'h4;
      resultIn <= 8'h01;
      carryIn <= 1'b0;
      nibbleIn <= 1'b0;
      @(posedge core_clk);
      flagUpdate <= 1'b0;
      acc(ADDR_FLAGS, 0, 8'h00); chk("arith flags", q, 10'h0FB);
      @(posedge core_clk) sleepInstr <= 1'b1;
      @(posedge core_clk) sleepInstr <= 1'b0;
      acc(ADDR_FLAGS, 0, 8'h00); chk("after sleep", q, 10'h0F3);
      @(posedge core_clk) watchdogTimeout <= 1'b1;
      @(posedge core_clk) watchdogTimeout <= 1'b0;
      accBank <= 2'h2;
      acc(ADDR_FLAGS, 0, 8'h00); chk("after expiry", q, 10'h0E3);
      @(posedge core_clk) watchdogClearInstr <= 1'b1;
      @(posedge core_clk) watchdogClearInstr <= 1'b0;
      acc(ADDR_FLAGS, 0, 8'h00); chk("after clear", q, 10'h0FB);
      $display("flags test done");
   endtask : t_flags

   task automatic t_indirect();
      acc(ADDR_FILE_SELECT, 1, 8'hA5); chk("loc", pointerLoc, 10'h025);
      acc(ADDR_FILE_SELECT, 0, 8'h00); chk("pointer", q, 10'h0A5);
      acc(ADDR_INDIRECT_WINDOW, 1, 8'h5A);
      chk("mem addr", lastAddr, 10'h1A5);
      chk("mem data", lastData, 10'h05A);
      acc(7'h30, 1, 8'hC3);
      acc(ADDR_INDIRECT_WINDOW, 0, 8'h00); chk("window read", q, 10'h05A);
      @(posedge core_clk) accIndirect <= 1'b1;
      acc(7'h30, 0, 8'h00); chk("pointer read", q, 10'h05A);
      @(posedge core_clk) accIndirect <= 1'b0;
      $display("indirect test done");
   endtask : t_indirect

   task automatic t_timer();
      acc(ADDR_TIMER_COUNT, 1, 8'hFE);
      acc(ADDR_TIMER_COUNT, 0, 8'h00); chk("timer load", q, 10'h0FE);
      tick(2);
      acc(ADDR_TIMER_COUNT, 0, 8'h00); chk("timer instr", q, 10'h000);
      @(posedge core_clk) timerSourceMode <= 1'b1;
      repeat (2) begin
         repeat (4) @(posedge core_clk);
         externalCountInput <= 1'b1;
         repeat (4) @(posedge core_clk);
         externalCountInput <= 1'b0;
      end
      tick(1);
      acc(ADDR_TIMER_COUNT, 0, 8'h00); chk("timer pin", q, 10'h002);
      @(posedge core_clk) cfgLowOsc <= 1'b1;
      repeat (4) @(posedge core_clk);
      lowOscClock <= 1'b1;
      repeat (6) @(posedge core_clk);
      acc(ADDR_TIMER_COUNT, 0, 8'h00); chk("timer osc", q, 10'h003);
      $display("timer test done");
   endtask : t_timer

   initial begin
      {resetn, instrDone, accIndirect, accRead, accWrite, longJump, longSubroutineJump} = '0;
      {flagUpdate, carryIn, nibbleIn, watchdogClearInstr, sleepInstr, watchdogTimeout} = '0;
      {timerSourceMode, cfgLowOsc, externalCountInput, lowOscClock} = '0;
      {accBank, accAddr, accWdata, resultIn, jumpTarget, flagMask} = '0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset();
      t_pc();
      t_flags();
      t_indirect();
      t_timer();
      close_out();
   end

   initial begin
      #100us;
      error_cnt++;
      close_out();
   end
endmodule : test_core_special_registers
`default_nettype wire
